// ---- pkg/spd_pkg.sv ----
// constants, register map and field layout of the serial-to-parallel converter
//
// Notes on behaviour
// [R1] edge mode select high: one serial bit taken per clock, rising edge only
// [R2] edge mode select low: two serial bits taken per clock, both edges
// [R3] edge mode select resets low, so dual-edge capture is the default
// [R4] input select picks primary or alternate serial input; primary by default
// [R5] every control bit resets to zero, reading as logic low
// [R6] state is only trusted after a reset has been applied
// [R7] while master reset is held, the internal clock stays stopped
// [R8] after reset release the first bit is taken after a short start holdoff
// [R9] dual-edge mode: bit reaches the parallel outputs 6 clocks after sampling
// [R10] rising-only mode: bit reaches the parallel outputs 8 clocks after sampling
// [R11] a recognised slip request drops one bit, moving each bit one place lower
// [R12] dual-edge mode: slip request must stay high two consecutive clocks
// [R13] rising-only mode: slip request must stay high three consecutive clocks
// [R14] each slip pulse gives exactly one bit of shift, one per pulse
// [R15] clock gate is sampled synchronously; asserted, it stops internal clock
// [R16] while gated off nothing moves and no partial word step occurs
// [R17] suspension begins at the clock edge after the gate bit goes high
// [R18] operation resumes at the edge after the gate bit goes low
// [R19] dual-edge mode: word framing clock is the input clock divided by 4
// [R20] rising-only mode: word framing clock is the input clock divided by 8
// [R21] earliest bit of a word lands on the lowest parallel output
// [R22] reset acts asynchronously, clearing sampling and framing state at once
// [R23] parallel outputs change once per word, in step with the framing clock
`default_nettype none

package spd_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // control fields
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_SEL_BIT  = 1;
  localparam int CTRL_GATE_BIT = 2;
  localparam int CTRL_SRST_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status fields
  localparam int STAT_WORD_LSB  = 0;
  localparam int STAT_COUNT_LSB = 8;
  localparam int STAT_RUN_BIT   = 24;
  localparam int STAT_PEND_BIT  = 25;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int WORD_BITS  = 8;
  localparam int DUAL_EXTRA = 2;
  localparam int RISE_EXTRA = 4;
  localparam logic [1:0] SLIP_DUAL  = 2'h2;
  localparam logic [1:0] SLIP_RISE  = 2'h3;
  localparam logic [1:0] START_HOLD = 2'h2;
  localparam logic [3:0] WCLK_HALF  = 4'h4;

endpackage : spd_pkg

`default_nettype wire

// ---- logic/spd_conv.sv ----
// one-to-eight serial-to-parallel converter with an AHB-Lite control port
`default_nettype none

module spd_conv #(
  parameter int ADDR_W = 32
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire logic [1:0]        serial_in_primary,
  input  wire logic [1:0]        serial_in_alternate,
  input  wire logic              bit_slip_req,
  output logic      [7:0]        parallel_out,
  output logic                   word_clk
);

  if (ADDR_W < 8) begin : g_chk
    $error("spd_conv: ADDR_W must be at least 8");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       sa1;
    logic [1:0]       sa2;
    logic [1:0]       sb1;
    logic [1:0]       sb2;
    logic             slip1;
    logic             slip2;
    logic             edge_sel;
    logic             in_sel;
    logic             gate;
    logic             srst;
    logic [3:0][1:0]  dly;
    logic [3:0]       dv;
    logic [7:0]       bitbuf;
    logic [3:0]       cnt;
    logic [7:0]       par;
    logic             emit;
    logic             wclk;
    logic [1:0]       hold;
    logic [1:0]       slip_cnt;
    logic             fired;
    logic             slip_pend;
    logic [15:0]      words;
    logic             a_ph;
    logic             a_wr;
    logic [7:0]       a_addr;
    logic [31:0]      rdata;
  } spd_state_s;

  spd_state_s s_r;
  spd_state_s s_nxt;

  logic       run;
  logic [1:0] lane;
  logic [1:0] tap;
  logic       tap_v;
  logic       drop;
  logic [1:0] need;

  always_comb begin
    s_nxt = s_r;
    drop  = 1'b0;
    // synchronisers: first stage feeds only the second
    s_nxt.sa1   = serial_in_primary;
    s_nxt.sa2   = s_r.sa1;
    s_nxt.sb1   = serial_in_alternate;
    s_nxt.sb2   = s_r.sb1;
    s_nxt.slip1 = bit_slip_req;
    s_nxt.slip2 = s_r.slip1;

    run  = !s_r.srst && !s_r.gate && (s_r.hold == 2'h0); // [R7] [R15] [R16] [R17]
    lane = s_r.in_sel ? s_r.sb2 : s_r.sa2; // [R4]
    tap   = s_r.edge_sel ? s_r.dly[spd_pkg::RISE_EXTRA-1]
                         : s_r.dly[spd_pkg::DUAL_EXTRA-1];
    tap_v = s_r.edge_sel ? s_r.dv[spd_pkg::RISE_EXTRA-1]
                         : s_r.dv[spd_pkg::DUAL_EXTRA-1];
    need  = s_r.edge_sel ? spd_pkg::SLIP_RISE : spd_pkg::SLIP_DUAL;
    s_nxt.emit = 1'b0;

    // ------------------------------------------------------------------
    // slip qualifier: counts consecutive high cycles, fires once per pulse
    // ------------------------------------------------------------------
    if (s_r.slip2) begin
      if (s_r.slip_cnt < need) begin
        s_nxt.slip_cnt = s_r.slip_cnt + 2'h1;
      end
      if ((s_r.slip_cnt + 2'h1 == need) && !s_r.fired) begin
        s_nxt.fired     = 1'b1; // [R12] [R13] [R14]
        s_nxt.slip_pend = 1'b1;
      end
    end else begin
      s_nxt.slip_cnt = 2'h0;
      s_nxt.fired    = 1'b0;
    end

    if (s_r.srst) begin
      // soft master reset clears the datapath and restarts the holdoff
      s_nxt.dv        = 4'h0; // [R7]
      s_nxt.cnt       = 4'h0;
      s_nxt.bitbuf    = 8'h00;
      s_nxt.wclk      = 1'b0;
      s_nxt.hold      = spd_pkg::START_HOLD;
      s_nxt.slip_pend = 1'b0;
    end else if (!s_r.gate && s_r.hold != 2'h0) begin
      s_nxt.hold = s_r.hold - 2'h1; // [R8]
    end else if (run) begin
      // fixed delay line sets the end-to-end latency per mode
      s_nxt.dly = {s_r.dly[2:0], lane}; // [R9] [R10]
      s_nxt.dv  = {s_r.dv[2:0], 1'b1};
      if (tap_v) begin
        drop = s_r.slip_pend;
        if (drop) begin
          s_nxt.slip_pend = s_nxt.fired && !s_r.fired; // [R11]
        end
        for (int k = 0; k < 2; k++) begin
          if (k == 0 || !s_r.edge_sel) begin // [R1] [R2]
            if (drop) begin
              drop = 1'b0; // [R11]
            end else begin
              s_nxt.bitbuf[s_nxt.cnt[2:0]] = tap[k]; // [R21]
              s_nxt.cnt = s_nxt.cnt + 4'h1;
              if (s_nxt.cnt == 4'(spd_pkg::WORD_BITS)) begin
                s_nxt.par   = s_nxt.bitbuf; // [R23]
                s_nxt.emit  = 1'b1;
                s_nxt.cnt   = 4'h0;
                s_nxt.words = s_r.words + 16'h0001;
              end
            end
          end
        end
        s_nxt.wclk = s_nxt.cnt < spd_pkg::WCLK_HALF; // [R19] [R20]
      end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    if (s_r.a_ph && s_r.a_wr) begin
      if (s_r.a_addr == spd_pkg::CTRL_OFS) begin
        s_nxt.edge_sel = hwdata[spd_pkg::CTRL_EDGE_BIT]; // [R1] [R2]
        s_nxt.in_sel   = hwdata[spd_pkg::CTRL_SEL_BIT];
        s_nxt.gate     = hwdata[spd_pkg::CTRL_GATE_BIT]; // [R15] [R18]
        s_nxt.srst     = hwdata[spd_pkg::CTRL_SRST_BIT];
      end
    end
    s_nxt.a_ph   = hsel && htrans[1] && hready;
    s_nxt.a_wr   = hwrite;
    s_nxt.a_addr = haddr[7:0];
    s_nxt.rdata  = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == spd_pkg::CTRL_OFS) begin
        s_nxt.rdata[spd_pkg::CTRL_EDGE_BIT] = s_r.edge_sel;
        s_nxt.rdata[spd_pkg::CTRL_SEL_BIT]  = s_r.in_sel;
        s_nxt.rdata[spd_pkg::CTRL_GATE_BIT] = s_r.gate;
        s_nxt.rdata[spd_pkg::CTRL_SRST_BIT] = s_r.srst;
      end else if (haddr[7:0] == spd_pkg::STAT_OFS) begin
        s_nxt.rdata[spd_pkg::STAT_WORD_LSB +: 8]   = s_r.par;
        s_nxt.rdata[spd_pkg::STAT_COUNT_LSB +: 16] = s_r.words;
        s_nxt.rdata[spd_pkg::STAT_RUN_BIT]         = run;
        s_nxt.rdata[spd_pkg::STAT_PEND_BIT]        = s_r.slip_pend;
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r      <= '0; // [R22] [R5] [R6]
      s_r.hold <= spd_pkg::START_HOLD; // [R8]
      {s_r.edge_sel, s_r.in_sel, s_r.gate, s_r.srst} <=
        spd_pkg::CTRL_RESET; // [R3] [R4] [R5]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = s_r.rdata;
  assign parallel_out = s_r.par;
  assign word_clk     = s_r.wclk;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_par_only_emit: assert property ( // [R23]
    $changed(s_r.par) |-> s_r.emit)
    else $error("parallel word changed without a word boundary");

  a_gate_freeze: assert property ( // [R16]
    s_r.gate |=> $stable(s_r.cnt) && $stable(s_r.par) && $stable(s_r.wclk))
    else $error("datapath moved while gated off");

  a_reset_stop: assert property ( // [R7]
    s_r.srst |=> (s_r.cnt == 4'h0) && (s_r.dv == 4'h0) && !s_r.wclk)
    else $error("datapath active during master reset");

  a_hold_start: assert property ( // [R8]
    (s_r.hold != 2'h0) |=> $stable(s_r.dv) || s_r.srst)
    else $error("sampling started inside the start holdoff");

  a_slip_pend: assert property ( // [R14]
    $rose(s_r.fired) |-> s_r.slip_pend)
    else $error("qualified slip did not raise a pending drop");

  a_slip_dual: assert property ( // [R12]
    $rose(s_r.fired) |-> $past(s_r.slip2) && $past(s_r.slip2, 2))
    else $error("slip fired before two high cycles");

  a_slip_rise: assert property ( // [R13]
    $rose(s_r.fired) && $past(s_r.edge_sel) |-> $past(s_r.slip2, 3))
    else $error("slip fired before three high cycles");

  a_wclk_emit: assert property ( // [R19]
    s_r.emit && !s_r.edge_sel && !$past(s_r.slip_pend) |->
      s_r.wclk ##1 (s_r.wclk || $past(s_r.srst)))
    else $error("framing clock out of step with the word");

  a_wclk_rise: assert property ( // [R20]
    s_r.emit && s_r.edge_sel && !$past(s_r.slip_pend) |->
      s_r.wclk ##1 (s_r.wclk || $past(s_r.srst)))
    else $error("framing clock out of step in rising-only mode");

  a_wclk_level: assert property ( // [R19] [R20]
    run && tap_v |=> s_r.wclk == (s_r.cnt < spd_pkg::WCLK_HALF))
    else $error("framing clock level does not follow the bit count");

  // ------------------------------------------------------------------
  // capture per edge mode
  // ------------------------------------------------------------------
  // the count step is what tells one bit per clock from two; a stuck
  // lane mux would still pack words, so the step is checked directly

  a_edge_rise_one: assert property ( // [R1]
    run && tap_v && s_r.edge_sel && !s_r.slip_pend |=>
      s_r.cnt[2:0] == $past(s_r.cnt[2:0]) + 3'h1)
    else $error("rising-only mode did not take exactly one bit");

  a_edge_dual_two: assert property ( // [R2]
    run && tap_v && !s_r.edge_sel && !s_r.slip_pend |=>
      s_r.cnt[2:0] == $past(s_r.cnt[2:0]) + 3'h2)
    else $error("dual-edge mode did not take exactly two bits");

  a_ctrl_edge: assert property ( // [R1] [R2]
    s_r.a_ph && s_r.a_wr && (s_r.a_addr == spd_pkg::CTRL_OFS) |=>
      s_r.edge_sel == $past(hwdata[spd_pkg::CTRL_EDGE_BIT]))
    else $error("edge mode write did not land");

  a_lane_pri: assert property ( // [R4]
    run && !s_r.in_sel |=> s_r.dly[0] == $past(s_r.sa2))
    else $error("primary lane not taken into the delay line");

  a_lane_alt: assert property ( // [R4]
    run && s_r.in_sel |=> s_r.dly[0] == $past(s_r.sb2))
    else $error("alternate lane not taken into the delay line");

  a_sync_pri: assert property (
    s_r.sa2 == $past(s_r.sa1))
    else $error("primary lane synchroniser skipped a stage");

  a_sync_slip: assert property ( // [R12] [R13]
    s_r.slip2 == $past(s_r.slip1))
    else $error("slip request synchroniser skipped a stage");

  // ------------------------------------------------------------------
  // latency line
  // ------------------------------------------------------------------

  a_dly_shift: assert property ( // [R9] [R10]
    run |=> s_r.dly[3:1] == $past(s_r.dly[2:0]))
    else $error("delay line did not advance one stage");

  a_dv_fill: assert property ( // [R9] [R10]
    run |=> s_r.dv[0])
    else $error("delay line valid did not fill");

  a_dly_freeze: assert property ( // [R16]
    !run |=> $stable(s_r.dly))
    else $error("delay line moved while stopped");

  // ------------------------------------------------------------------
  // slip
  // ------------------------------------------------------------------
  // a drop must cost exactly one bit; losing two would shift the word
  // by two places and the consumer could never realign by single steps

  a_slip_drop_dual: assert property ( // [R11]
    run && tap_v && !s_r.edge_sel && s_r.slip_pend |=>
      s_r.cnt[2:0] == $past(s_r.cnt[2:0]) + 3'h1)
    else $error("dual-edge slip did not drop exactly one bit");

  a_slip_drop_rise: assert property ( // [R11]
    run && tap_v && s_r.edge_sel && s_r.slip_pend |=>
      $stable(s_r.cnt))
    else $error("rising-only slip did not drop exactly one bit");

  a_slip_clear: assert property ( // [R14]
    run && tap_v && s_r.slip_pend |=>
      !s_r.slip_pend || $rose(s_r.fired))
    else $error("pending drop applied more than once");

  // ------------------------------------------------------------------
  // start, soft reset and gate
  // ------------------------------------------------------------------

  a_gate_run: assert property ( // [R17]
    s_r.gate |-> !run)
    else $error("datapath running while gated off");

  a_srst_run: assert property ( // [R7]
    s_r.srst |-> !run)
    else $error("datapath running during master reset");

  a_hold_run: assert property ( // [R8]
    (s_r.hold != 2'h0) |-> !run)
    else $error("datapath running inside the start holdoff");

  a_srst_hold: assert property ( // [R8]
    $fell(s_r.srst) |-> s_r.hold == spd_pkg::START_HOLD)
    else $error("holdoff not restarted after master reset");

  a_hold_count: assert property ( // [R8]
    (s_r.hold != 2'h0) && !s_r.gate && !s_r.srst |=>
      s_r.hold == $past(s_r.hold) - 2'h1)
    else $error("start holdoff did not count down");

  a_ctrl_gate: assert property ( // [R15] [R18]
    s_r.a_ph && s_r.a_wr && (s_r.a_addr == spd_pkg::CTRL_OFS) |=>
      s_r.gate == $past(hwdata[spd_pkg::CTRL_GATE_BIT]))
    else $error("clock gate write did not land");

  // ------------------------------------------------------------------
  // word output
  // ------------------------------------------------------------------

  a_emit_run: assert property ( // [R16]
    s_r.emit |-> $past(run))
    else $error("word emitted while stopped");

  a_emit_cnt: assert property ( // [R23]
    s_r.emit |-> s_r.cnt <= 4'h1)
    else $error("word emitted away from the word boundary");

  a_cnt_range: assert property ( // [R23]
    s_r.cnt < 4'(spd_pkg::WORD_BITS))
    else $error("bit count left the word");

  a_words_step: assert property ( // [R23]
    s_r.emit |-> s_r.words == $past(s_r.words) + 16'h0001)
    else $error("word count did not step on a word");

  a_words_hold: assert property ( // [R23]
    !s_r.emit |-> $stable(s_r.words))
    else $error("word count moved without a word");

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  // the port never stalls, so a master that waits on ready must see it
  // high in every cycle or the bench would hang

  a_ready_high: assert property (
    hreadyout)
    else $error("register port inserted a wait state");

  a_resp_okay: assert property (
    !hresp)
    else $error("register port gave an error response");

  a_rdata_idle: assert property (
    !$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0)
    else $error("read data present outside a read data phase");

endmodule : spd_conv

`default_nettype wire

// ---- test/spd_src.sv ----
// serial bit stream source feeding both serial inputs of the converter
`default_nettype none

module spd_src (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       toggle,
  output logic      [1:0] lane_pri,
  output logic      [1:0] lane_alt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ph_r;

  // ---------------------------------------------------------------
  // stream phase
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
    end
  end

  // dual edge: first lane 1, second lane 0 makes an alternating stream
  // toggle: the rising lane alternates per clock for rising-only mode
  assign lane_pri = toggle ? {1'b0, ph_r} : 2'h1;
  // all ones on the alternate path tells the two inputs apart
  assign lane_alt = 2'h3;
endmodule // spd_src

`default_nettype wire

// ---- test/test_serial_to_parallel_deserializer.sv ----
// self-checking bench of the converter: bus tasks and stream scenarios
`default_nettype none

module test_serial_to_parallel_deserializer;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slip, tgl;
  logic        word_clk;
  logic [31:0] haddr, hwdata, hrdata, rd, w;
  logic [1:0]  htrans, pri, alt;
  logic [2:0]  hsize;
  logic [7:0]  pout;
  int          n_errors, num_checks;

  spd_src i_src (.hclk(hclk), .hresetn(hresetn), .toggle(tgl),
                 .lane_pri(pri), .lane_alt(alt));

  spd_conv i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_in_primary(pri),
    .serial_in_alternate(alt), .bit_slip_req(slip),
    .parallel_out(pout), .word_clk(word_clk));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rd = hrdata;
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // slip request held high for n clocks, then dropped to rearm
  task automatic pulse(input int n);
    @(posedge hclk);
    slip <= 1'b1;
    repeat (n) @(posedge hclk);
    slip <= 1'b0;
    settle(40);
  endtask

  task automatic period(input logic [31:0] exp);
    realtime t0;
    @(posedge word_clk);
    t0 = $realtime;
    @(posedge word_clk);
    chk(32'(int'(($realtime - t0) / 8.0)), exp);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock and watchdog; reset is driven by the scenarios
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    #100000;
    n_errors++;
    conclude;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    hresetn <= 1'b0; hsel <= 1'b0; htrans <= 2'h0; haddr <= 32'h0;
    hwrite <= 1'b0; hsize <= 3'h2; hwdata <= 32'h0; slip <= 1'b0;
    tgl <= 1'b0; n_errors = 0; num_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0);
    settle(40);
    chk(32'(pout), 32'h55);
    period(32'h4);
    ahb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[7:0]), 32'h55);
    pulse(2);
    chk(32'(pout), 32'haa);
    pulse(6);
    chk(32'(pout), 32'h55);
    ahb(1'b1, 32'h0, 32'h2);
    settle(40);
    chk(32'(pout), 32'hff);
    tgl <= 1'b1;
    ahb(1'b1, 32'h0, 32'h1);
    settle(60);
    w = 32'(pout);
    chk(32'((w == 32'h55) || (w == 32'haa)), 32'h1);
    period(32'h8);
    pulse(2);
    chk(32'(pout), w);
    pulse(3);
    chk(32'(pout), w ^ 32'hff);
    ahb(1'b1, 32'h0, 32'h5);
    settle(4);
    ahb(1'b0, 32'h4, 32'h0);
    w = rd;
    chk(32'(w[24]), 32'h0);
    settle(30);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, w);
    ahb(1'b1, 32'h0, 32'h1);
    settle(30);
    ahb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[23:8] != w[23:8]), 32'h1);
    ahb(1'b1, 32'h0, 32'h9);
    settle(4);
    ahb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[24]), 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    settle(40);
    ahb(1'b0, 32'h4, 32'h0);
    chk(32'(rd[24]), 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    chk({23'h0, word_clk, pout}, 32'h0);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    conclude;
  end
endmodule // test_serial_to_parallel_deserializer

`default_nettype wire
